/* File: core/adc_calibration_control_defines.vh */
// constants for the converter calibration and control block
`ifndef ADC_CALIBRATION_CONTROL_DEFINES_VH
`define ADC_CALIBRATION_CONTROL_DEFINES_VH

// register byte offsets
`define CTRL_OFFSET        6'h00
`define FULL_SCALE_OFFSET  6'h04
`define STATUS_OFFSET      6'h08
`define INT_STATUS_OFFSET  6'h0C
`define INT_MASK_OFFSET    6'h10

// control register fields
`define CTRL_EXTENDED_BIT  0
`define CTRL_SECOND_CLK_BIT 1
`define CTRL_TRIM_SKIP_BIT 2

// interrupt status fields
`define INT_CAL_DONE_BIT   0
`define INT_RANGE_BIT      1
`define INT_IGNORED_BIT    2

// reset values
`define CTRL_RESET         3'h0
`define FULL_SCALE_RESET   8'h80
`define INT_MASK_RESET     3'h0

// request qualification counts, in sample clock cycles
`define REQUEST_LOW_HOLD_CYCLES  8'h50
`define REQUEST_HIGH_HOLD_CYCLES 8'h50

// calibration phase defaults, in sample clock cycles
`define CAL_DELAY_SHORT_DEFAULT  24'h010000
`define CAL_DELAY_LONG_DEFAULT   24'h100000
`define TRIM_PHASE_DEFAULT       24'h000400
`define ADC_PHASE_DEFAULT        24'h008000

// bus responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* File: core/pin_sync.v */
// two-stage synchroniser for asynchronous control pins
module pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             i_mclk,
  input  wire             i_reset,
  input  wire [WIDTH-1:0] i_d,
  output reg  [WIDTH-1:0] o_q
);

  reg [WIDTH-1:0] meta_reg;

  // the first stage feeds only the second stage
  always @(posedge i_mclk) begin
    if (i_reset) begin
      meta_reg <= {WIDTH{1'b0}};
      o_q      <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule

/* File: core/adc_calibration_control.v */
// calibration sequencing, range flag, data clock and full-scale control
`include "adc_calibration_control_defines.vh"

module adc_calibration_control #(
  parameter [23:0] CAL_DELAY_SHORT_CYCLES = `CAL_DELAY_SHORT_DEFAULT,
  parameter [23:0] CAL_DELAY_LONG_CYCLES  = `CAL_DELAY_LONG_DEFAULT,
  parameter [23:0] TRIM_PHASE_CYCLES      = `TRIM_PHASE_DEFAULT,
  parameter [23:0] ADC_PHASE_CYCLES       = `ADC_PHASE_DEFAULT
) (
  input  wire        i_mclk,
  input  wire        i_reset,
  // control pins
  input  wire        i_cal_request,
  input  wire        i_power_down_input,
  input  wire        i_calibration_delay_select,
  input  wire        i_full_scale_select,
  input  wire        i_clock_running,
  // accurate conversion results, two's complement, same clock
  input  wire [9:0]  i_result_a,
  input  wire [9:0]  i_result_b,
  // converter-side outputs
  output reg         o_calibration_active,
  output reg         o_output_data_clock,
  output reg         o_range_p,
  output reg         o_range_n,
  output reg         o_full_scale_normal,
  output reg         o_full_scale_from_reg,
  output reg  [7:0]  o_full_scale_adjust,
  output reg         o_analog_power_down,
  output reg         o_irq,
  // AXI4-Lite slave
  input  wire [5:0]  i_s_axi_awaddr,
  input  wire        i_s_axi_awvalid,
  output reg         o_s_axi_awready,
  input  wire [31:0] i_s_axi_wdata,
  input  wire [3:0]  i_s_axi_wstrb,
  input  wire        i_s_axi_wvalid,
  output reg         o_s_axi_wready,
  output reg  [1:0]  o_s_axi_bresp,
  output reg         o_s_axi_bvalid,
  input  wire        i_s_axi_bready,
  input  wire [5:0]  i_s_axi_araddr,
  input  wire        i_s_axi_arvalid,
  output reg         o_s_axi_arready,
  output reg  [31:0] o_s_axi_rdata,
  output reg  [1:0]  o_s_axi_rresp,
  output reg         o_s_axi_rvalid,
  input  wire        i_s_axi_rready
);

  localparam [2:0] ST_STRAP = 3'h0;
  localparam [2:0] ST_DELAY = 3'h1;
  localparam [2:0] ST_IDLE  = 3'h2;
  localparam [2:0] ST_TRIM  = 3'h3;
  localparam [2:0] ST_CAL   = 3'h4;
  wire [4:0] pin_q;
  pin_sync #(
    .WIDTH(5)
  ) u_pin_sync (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .i_d     ({i_clock_running, i_full_scale_select, i_calibration_delay_select,
               i_power_down_input, i_cal_request}),
    .o_q     (pin_q)
  );
  wire       req_pin       = pin_q[0];
  wire       pd_pin        = pin_q[1];
  wire       delay_sel_pin = pin_q[2];
  wire       fss_pin       = pin_q[3];
  wire       clk_run_pin   = pin_q[4];
  reg  [2:0]  ctrl_reg;
  reg  [7:0]  fsa_reg;
  reg  [2:0]  int_status_reg;
  reg  [2:0]  int_mask_reg;
  reg  [2:0]  state_reg;
  reg  [1:0]  start_cnt_reg;
  reg  [23:0] phase_cnt_reg;
  reg         poweron_reg;
  reg         skip_reg;
  reg         pd_state_reg;
  reg         req_prev_reg;
  reg  [7:0]  run_cnt_reg;
  reg         low_ok_reg;
  reg         armed_reg;
  reg         range_prev_reg;
  wire extended   = ctrl_reg[`CTRL_EXTENDED_BIT];
  wire second_clk = ctrl_reg[`CTRL_SECOND_CLK_BIT];
  wire trim_skip  = ctrl_reg[`CTRL_TRIM_SKIP_BIT];
  wire calibrating = (state_reg == ST_TRIM) || (state_reg == ST_CAL);
  // request qualifier: run length at the current level, this sample included
  wire [7:0] run_len = (req_pin == req_prev_reg) ?
                       ((run_cnt_reg == 8'hFF) ? 8'hFF : run_cnt_reg + 8'h01) : 8'h01;
  wire req_rise  = req_pin && !req_prev_reg;
  wire cal_start = req_pin && armed_reg && (run_len == `REQUEST_HIGH_HOLD_CYCLES)
                   && !pd_state_reg;
  wire ev_ignored = pd_state_reg && req_rise;
  always @(posedge i_mclk) begin
    if (i_reset) begin
      req_prev_reg <= 1'b0;
      run_cnt_reg  <= 8'h00;
      low_ok_reg   <= 1'b0;
      armed_reg    <= 1'b0;
    end else begin
      req_prev_reg <= req_pin;
      run_cnt_reg  <= run_len;
      if (pd_state_reg) begin
        // a request must be qualified afresh after power down
        low_ok_reg <= 1'b0;
        armed_reg  <= 1'b0;
      end else if (!req_pin) begin
        armed_reg <= 1'b0;
        if (run_len >= `REQUEST_LOW_HOLD_CYCLES) begin
          low_ok_reg <= 1'b1;
        end
      end else if (req_rise) begin
        armed_reg  <= low_ok_reg;
        low_ok_reg <= 1'b0;
      end else if (cal_start) begin
        armed_reg <= 1'b0;
      end
    end
  end

  // power-on delay choice; extended mode forces the short one
  wire        use_long     = !extended && delay_sel_pin;
  wire [23:0] delay_target = use_long ? CAL_DELAY_LONG_CYCLES : CAL_DELAY_SHORT_CYCLES;
  always @(posedge i_mclk) begin
    if (i_reset) begin
      state_reg     <= ST_STRAP;
      start_cnt_reg <= 2'h0;
      phase_cnt_reg <= 24'h000000;
      poweron_reg   <= 1'b0;
      skip_reg      <= 1'b0;
    end else begin
      case (state_reg)
        ST_STRAP: begin
          // wait for the synchroniser to carry real pin levels
          start_cnt_reg <= start_cnt_reg + 2'h1;
          if (start_cnt_reg == 2'h3) begin
            phase_cnt_reg <= 24'h000000;
            state_reg     <= req_pin ? ST_IDLE : ST_DELAY;
          end
        end
        ST_DELAY: begin
          if (cal_start) begin
            phase_cnt_reg <= 24'h000000;
            poweron_reg   <= 1'b0;
            skip_reg      <= extended && trim_skip;
            state_reg     <= (extended && trim_skip) ? ST_CAL : ST_TRIM;
          end else if (!pd_pin && clk_run_pin) begin
            // counting only on a running clock makes late clocks look alike
            if (phase_cnt_reg + 24'h000001 >= delay_target) begin
              phase_cnt_reg <= 24'h000000;
              poweron_reg   <= 1'b1;
              skip_reg      <= 1'b0;
              state_reg     <= ST_TRIM;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 24'h000001;
            end
          end
        end
        ST_IDLE: begin
          if (cal_start) begin
            phase_cnt_reg <= 24'h000000;
            poweron_reg   <= 1'b0;
            skip_reg      <= extended && trim_skip;
            state_reg     <= (extended && trim_skip) ? ST_CAL : ST_TRIM;
          end
        end
        ST_TRIM: begin
          if (phase_cnt_reg + 24'h000001 >= TRIM_PHASE_CYCLES) begin
            phase_cnt_reg <= 24'h000000;
            state_reg     <= ST_CAL;
          end else begin
            phase_cnt_reg <= phase_cnt_reg + 24'h000001;
          end
        end
        ST_CAL: begin
          if (phase_cnt_reg + 24'h000001 >= ADC_PHASE_CYCLES) begin
            phase_cnt_reg <= 24'h000000;
            poweron_reg   <= 1'b0;
            state_reg     <= ST_IDLE;
          end else begin
            phase_cnt_reg <= phase_cnt_reg + 24'h000001;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  wire cal_done = (state_reg == ST_CAL) && (phase_cnt_reg + 24'h000001 >= ADC_PHASE_CYCLES);
  // power down never cuts a calibration short, nor one starting this cycle
  always @(posedge i_mclk) begin
    if (i_reset) begin
      pd_state_reg <= 1'b0;
    end else if (!pd_pin) begin
      pd_state_reg <= 1'b0;
    end else if (!calibrating && !cal_start) begin
      pd_state_reg <= 1'b1;
    end
  end
  // clipping: negative, or above 8'hFF
  wire clip_a  = i_result_a[9] || i_result_a[8];
  wire clip_b  = i_result_b[9] || i_result_b[8];
  wire clipped = clip_a || clip_b;
  wire output_data_clock_en = !pd_state_reg && !(calibrating && !skip_reg);

  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_calibration_active  <= 1'b0;
      o_output_data_clock   <= 1'b0;
      o_range_p             <= 1'b0;
      o_range_n             <= 1'b1;
      o_full_scale_normal   <= 1'b0;
      o_full_scale_from_reg <= 1'b0;
      o_full_scale_adjust   <= `FULL_SCALE_RESET;
      o_analog_power_down   <= 1'b1;
      range_prev_reg        <= 1'b0;
    end else begin
      o_calibration_active <= calibrating;
      o_output_data_clock  <= output_data_clock_en ? !o_output_data_clock : 1'b0;
      if (second_clk) begin
        o_range_p <= output_data_clock_en ? !o_output_data_clock : 1'b0;
        o_range_n <= output_data_clock_en ? o_output_data_clock : 1'b1;
      end else begin
        o_range_p <= clipped;
        o_range_n <= !clipped;
      end
      range_prev_reg        <= clipped;
      o_full_scale_normal   <= !extended && fss_pin;
      o_full_scale_from_reg <= extended;
      o_full_scale_adjust   <= fsa_reg;
      // the pending power-on sequence parks the analog side without a clock
      // pins are not yet trusted while the strap is judged, so stay parked then
      o_analog_power_down   <= pd_state_reg || (state_reg == ST_STRAP) ||
                               ((state_reg == ST_DELAY) && !clk_run_pin);
    end
  end
  // register bus: address and data may arrive in either order
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [5:0]  awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  wire wr_en  = aw_held_reg && w_held_reg && !o_s_axi_bvalid;
  wire wr_lo  = wr_en && wstrb_reg[0];
  wire wr_hit = (awaddr_reg[5:2] <= 4'h4);
  wire [2:0] events   = {ev_ignored, clipped && !range_prev_reg, cal_done};
  wire [2:0] clr_bits = (wr_lo && awaddr_reg == `INT_STATUS_OFFSET) ? wdata_reg[2:0] : 3'h0;
  always @(posedge i_mclk) begin
    if (i_reset) begin
      aw_held_reg     <= 1'b0;
      w_held_reg      <= 1'b0;
      awaddr_reg      <= 6'h00;
      wdata_reg       <= 32'h00000000;
      wstrb_reg       <= 4'h0;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= `RESP_OKAY;
      ctrl_reg        <= `CTRL_RESET;
      fsa_reg         <= `FULL_SCALE_RESET;
      int_mask_reg    <= `INT_MASK_RESET;
      int_status_reg  <= 3'h0;
      o_irq           <= 1'b0;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held_reg     <= 1'b1;
        awaddr_reg      <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held_reg     <= 1'b1;
        wdata_reg      <= i_s_axi_wdata;
        wstrb_reg      <= i_s_axi_wstrb;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        aw_held_reg    <= 1'b0;
        w_held_reg     <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (wr_hit && awaddr_reg[1:0] == 2'h0) ? `RESP_OKAY : `RESP_SLVERR;
        if (wr_lo && awaddr_reg == `CTRL_OFFSET) begin
          ctrl_reg <= wdata_reg[2:0];
        end
        if (wr_lo && awaddr_reg == `FULL_SCALE_OFFSET) begin
          fsa_reg <= wdata_reg[7:0];
        end
        if (wr_lo && awaddr_reg == `INT_MASK_OFFSET) begin
          int_mask_reg <= wdata_reg[2:0];
        end
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
      // a new event outranks a clear in the same cycle
      int_status_reg <= (int_status_reg & ~clr_bits) | events;
      o_irq          <= |(int_status_reg & int_mask_reg);
    end
  end
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h00000000;
    case (i_s_axi_araddr)
      `CTRL_OFFSET:       rd_mux = {29'h00000000, ctrl_reg};
      `FULL_SCALE_OFFSET: rd_mux = {24'h000000, fsa_reg};
      `STATUS_OFFSET:     rd_mux = {26'h0000000, (state_reg == ST_DELAY), o_analog_power_down,
                                    pd_state_reg, clipped, poweron_reg, calibrating};
      `INT_STATUS_OFFSET: rd_mux = {29'h00000000, int_status_reg};
      `INT_MASK_OFFSET:   rd_mux = {29'h00000000, int_mask_reg};
      default:            rd_mux = 32'h00000000;
    endcase
  end
  wire rd_hit = (i_s_axi_araddr[5:2] <= 4'h4) && (i_s_axi_araddr[1:0] == 2'h0);
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= 32'h00000000;
      o_s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (i_s_axi_arvalid && o_s_axi_arready) begin
        o_s_axi_arready <= 1'b0;
        o_s_axi_rvalid  <= 1'b1;
        o_s_axi_rdata   <= rd_mux;
        o_s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_s_axi_rvalid && i_s_axi_rready) begin
        o_s_axi_rvalid  <= 1'b0;
        o_s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

/* File: tb/cal_host.sv */
// host-side model driving the calibration request pin
module cal_host (
  input  wire       i_mclk,
  input  wire       i_go,
  input  wire [7:0] i_low_cycles,
  output logic      o_request
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  initial o_request = 1'h1;
  // low run of i_low_cycles+1 samples, then high until the next go
  always @(posedge i_mclk) begin
    if (i_go) begin
      cnt <= i_low_cycles;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
    o_request <= !i_go && cnt == 8'h00;
  end
endmodule

/* File: tb/cal_ctrl_asserts.sv */
// concurrent checks on the calibration control ports
module cal_ctrl_asserts #(
  parameter [23:0] TRIM_PHASE_CYCLES = 24'h000008,
  parameter [23:0] ADC_PHASE_CYCLES  = 24'h000010
) (
  input wire i_mclk,
  input wire i_reset,
  input wire o_calibration_active,
  input wire o_output_data_clock,
  input wire o_range_p,
  input wire o_range_n,
  input wire o_full_scale_normal,
  input wire o_full_scale_from_reg,
  input wire o_analog_power_down,
  input wire i_s_axi_awvalid,
  input wire o_s_axi_awready,
  input wire i_s_axi_wvalid,
  input wire o_s_axi_wready,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  // the design quotes phase lengths as roughly plus or minus two
  localparam int LEN_LO = ADC_PHASE_CYCLES - 2;
  localparam int LEN_HI = TRIM_PHASE_CYCLES + ADC_PHASE_CYCLES + 2;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  a_reset_levels: assert property ($fell(i_reset) |-> !o_calibration_active && !o_output_data_clock
    && !o_range_p && o_range_n && o_analog_power_down && !o_s_axi_bvalid && !o_s_axi_rvalid)
    else $error("outputs not at reset levels");
  a_range_pair: assert property (o_range_n == !o_range_p)
    else $error("range pair legs not complementary");
  a_fs_source: assert property (o_full_scale_from_reg |-> !o_full_scale_normal)
    else $error("pin range used in extended mode");
  a_active_min: assert property ($rose(o_calibration_active) |-> o_calibration_active[*8])
    else $error("calibration active too short");
  a_active_max: assert property ($rose(o_calibration_active) |-> ##[LEN_LO:LEN_HI] !o_calibration_active)
    else $error("calibration active length wrong");
  a_active_powered: assert property (o_calibration_active |-> !o_analog_power_down)
    else $error("analog powered down while calibrating");
  a_write_answer: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
    |=> !o_s_axi_awready && !o_s_axi_wready ##1 o_s_axi_bvalid)
    else $error("write response missing");
  a_bvalid_release: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
    else $error("write response not released");
  a_read_answer: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid && !o_s_axi_arready)
    else $error("read response missing");
endmodule

bind adc_calibration_control cal_ctrl_asserts #(
  .TRIM_PHASE_CYCLES(TRIM_PHASE_CYCLES),
  .ADC_PHASE_CYCLES(ADC_PHASE_CYCLES)
) chk (
  .i_mclk(i_mclk), .i_reset(i_reset), .o_calibration_active(o_calibration_active),
  .o_output_data_clock(o_output_data_clock), .o_range_p(o_range_p), .o_range_n(o_range_n),
  .o_full_scale_normal(o_full_scale_normal), .o_full_scale_from_reg(o_full_scale_from_reg),
  .o_analog_power_down(o_analog_power_down), .i_s_axi_awvalid(i_s_axi_awvalid),
  .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid), .o_s_axi_wready(o_s_axi_wready),
  .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready), .i_s_axi_arvalid(i_s_axi_arvalid),
  .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rvalid(o_s_axi_rvalid)
);

/* File: tb/adc_calibration_control_tb.sv */
// self-checking bench for the calibration control block
`include "adc_calibration_control_defines.vh"
module adc_calibration_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, rst = 1'h1, strap_en = 1'h1, strap_val = 1'h0, go = 1'h0, host_req;
  logic        pd = 1'h0, dsel = 1'h0, fss = 1'h1, crun = 1'h1;
  logic [7:0]  low_n = 8'h50, fsa;
  logic [9:0]  res_a = 10'h080, res_b = 10'h080;
  logic [9:0]  vals [6] = '{10'h000, 10'h0FF, 10'h100, 10'h3FF, 10'h200, 10'h07F};
  logic        cal_act, output_data_clock, rp, rn, fsn, full_scale_select, apd, irq;
  logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          err_total = 0, n_compared = 0, cycles = 0;
  always #5 clk = ~clk;
  adc_calibration_control #(
    .CAL_DELAY_SHORT_CYCLES(24'h000014), .CAL_DELAY_LONG_CYCLES(24'h000028),
    .TRIM_PHASE_CYCLES(24'h000008), .ADC_PHASE_CYCLES(24'h000010)
  ) dut (
    .i_mclk(clk), .i_reset(rst), .i_cal_request(strap_en ? strap_val : host_req), .i_power_down_input(pd),
    .i_calibration_delay_select(dsel), .i_full_scale_select(fss), .i_clock_running(crun),
    .i_result_a(res_a), .i_result_b(res_b), .o_calibration_active(cal_act), .o_output_data_clock(output_data_clock),
    .o_range_p(rp), .o_range_n(rn), .o_full_scale_normal(fsn), .o_full_scale_from_reg(full_scale_select),
    .o_full_scale_adjust(fsa), .o_analog_power_down(apd), .o_irq(irq),
    .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
    .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready)
  );
  cal_host host (.i_mclk(clk), .i_go(go), .i_low_cycles(low_n), .o_request(host_req));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    bready <= 1'h0;
    check(bresp, `RESP_OKAY);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clk);
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    rready <= 1'h0;
    check(rdata, exp);
    check(rresp, er);
  endtask
  // waits for calibration_active rather than assuming when it ends
  task automatic expect_cal(input int lo, input int hi, input int len, input logic skip);
    int n;
    logic pv;
    n = 0;
    while (cal_act !== 1'h1 && n < hi) begin
      @(posedge clk);
      n++;
    end
    if (len == 0) begin
      check(cal_act, 1'h0);
    end else begin
      check(cal_act === 1'h1 && n >= lo, 1'h1);
      n = 1;
      pv = output_data_clock;
      while (n < 60) begin
        @(posedge clk);
        if (cal_act !== 1'h1) break;
        n++;
        check(output_data_clock, skip ? !pv : 1'h0);
        pv = output_data_clock;
      end
      check(n >= len - 2 && n <= len + 2, 1'h1);
    end
  endtask
  task automatic power_up(input logic sv, input logic ds, input int hold_pd, input int hold_clk, input int lo);
    @(posedge clk);
    rst <= 1'h1;
    strap_en <= 1'h1;
    strap_val <= sv;
    dsel <= ds;
    pd <= hold_pd > 0;
    crun <= hold_clk == 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    repeat (hold_pd + hold_clk) begin
      @(posedge clk);
      check({apd, cal_act}, 2'h2);
    end
    pd <= 1'h0;
    crun <= 1'h1;
    expect_cal(lo, lo + 14, sv ? 0 : 24, 1'h0);
  endtask
  task automatic start_req(input logic [7:0] low);
    repeat (4) @(posedge clk);
    low_n <= low;
    go <= 1'h1;
    strap_en <= 1'h0;
    @(posedge clk);
    go <= 1'h0;
  endtask
  task automatic request(input logic [7:0] low, input int len, input logic skip);
    start_req(low);
    expect_cal(low + 80, low + 94, len, skip);
  endtask
  task automatic pd_defer;
    int n;
    start_req(8'h50);
    n = 0;
    while (cal_act !== 1'h1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    pd <= 1'h1;
    while (cal_act === 1'h1 && n < 300) begin
      @(posedge clk);
      n++;
      if (cal_act === 1'h1) check(apd, 1'h0);
    end
    repeat (4) @(posedge clk);
    check(apd, 1'h1);
    rd_chk(`STATUS_OFFSET, 32'h18, `RESP_OKAY);
    pd <= 1'h0;
  endtask
  initial begin
    power_up(1'h0, 1'h0, 0, 0, 20);
    rd_chk(`FULL_SCALE_OFFSET, 32'h80, `RESP_OKAY);
    rd_chk(`CTRL_OFFSET, 32'h0, `RESP_OKAY);
    rd_chk(`INT_MASK_OFFSET, 32'h0, `RESP_OKAY);
    check(irq, 1'h0);
    rd_chk(`INT_STATUS_OFFSET, 32'h1, `RESP_OKAY);
    wr(`INT_MASK_OFFSET, 32'h1);
    rd_chk(`INT_MASK_OFFSET, 32'h1, `RESP_OKAY);
    check(irq, 1'h1);
    wr(`INT_STATUS_OFFSET, 32'h1);
    rd_chk(`INT_STATUS_OFFSET, 32'h0, `RESP_OKAY);
    check(irq, 1'h0);
    rd_chk(6'h3C, 32'h0, `RESP_SLVERR);
    power_up(1'h0, 1'h1, 0, 0, 40);
    power_up(1'h0, 1'h0, 30, 0, 20);
    power_up(1'h0, 1'h0, 0, 30, 20);
    power_up(1'h1, 1'h0, 0, 0, 40);
    request(8'h46, 0, 1'h0);
    request(8'h50, 24, 1'h0);
    pd <= 1'h1;
    request(8'h50, 0, 1'h0);
    rd_chk(`INT_STATUS_OFFSET, 32'h5, `RESP_OKAY);
    pd <= 1'h0;
    pd_defer();
    wr(`CTRL_OFFSET, 32'h5);
    wr(`FULL_SCALE_OFFSET, 32'h3C);
    rd_chk(`FULL_SCALE_OFFSET, 32'h3C, `RESP_OKAY);
    check({full_scale_select, fsn, fsa}, {2'h2, 8'h3C});
    request(8'h50, 16, 1'h1);
    wr(`CTRL_OFFSET, 32'h2);
    repeat (8) begin
      @(posedge clk);
      check({rp, rn}, {output_data_clock, !output_data_clock});
    end
    wr(`CTRL_OFFSET, 32'h0);
    for (int i = 0; i < 6; i++) begin
      res_a <= vals[i];
      res_b <= vals[5 - i];
      repeat (4) @(posedge clk);
      check(rp, |vals[i][9:8] | |vals[5 - i][9:8]);
    end
    rd_chk(`INT_STATUS_OFFSET, 32'h7, `RESP_OKAY);
    for (int i = 0; i < 2; i++) begin
      fss <= i[0];
      repeat (5) @(posedge clk);
      check(fsn, i[0]);
    end
    complete_run();
  end
endmodule
